//--- logic/nsr_ecc_lane.sv
// One byte lane: ECC status register and captured main and spare parity
`timescale 1ns/1ps
module nsr_ecc_lane (
  input wire logic clock,
  input wire logic rst,
  nsr_lane_if.lane port
);
  import nsr_pkg::*;

  nsr_ecc_status_t   next_status;
  logic [31:0]       next_main;
  logic [SPAR_W-1:0] next_spare;

  always_comb begin
    next_status = port.status;
    // Engine result wins over a software write in the same cycle
    if (port.check_done) begin
      next_status = nsr_ecc_status_t'(port.check_result & ECC_WMASK);
    end else if (port.sw_write) begin
      next_status = nsr_ecc_status_t'(port.sw_wdata & ECC_WMASK);
    end
    next_main  = port.main_load ? port.main_in : port.main_parity;
    next_spare = port.spare_load ? port.spare_in : port.spare_parity;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      port.status       <= nsr_ecc_status_t'(ECC_RESET);
      port.main_parity  <= PARITY_RESET;
      port.spare_parity <= PARITY_RESET[SPAR_W-1:0];
    end else begin
      port.status       <= next_status;
      port.main_parity  <= next_main;
      port.spare_parity <= next_spare;
    end
  end

  a_result_capture: assert property (@(posedge clock) disable iff (rst)
    port.check_done |=> port.status.main_err_index == $past(port.check_result.main_err_index)
      && port.status.spare_err_index == $past(port.check_result.spare_err_index))
    else $error("ECC location not captured");

  a_main_hold: assert property (@(posedge clock) disable iff (rst)
    !port.main_load [*2] |-> $stable(port.main_parity))
    else $error("main parity changed while not loading");

  a_spare_load: assert property (@(posedge clock) disable iff (rst)
    port.spare_load |=> port.spare_parity == $past(port.spare_in))
    else $error("spare parity not captured");

endmodule : nsr_ecc_lane

//--- logic/nsr_lane_if.sv
// Interface: one byte lane's ECC results, software writes and parity words
`timescale 1ns/1ps
interface nsr_lane_if;
  import nsr_pkg::*;
  logic              check_done;
  nsr_ecc_status_t   check_result;
  logic              sw_write;
  logic [31:0]       sw_wdata;
  nsr_ecc_status_t   status;
  logic              main_load;
  logic [31:0]       main_in;
  logic [31:0]       main_parity;
  logic              spare_load;
  logic [SPAR_W-1:0] spare_in;
  logic [SPAR_W-1:0] spare_parity;

  modport ctrl (output check_done, check_result, sw_write, sw_wdata, main_load, main_in,
                spare_load, spare_in, input status, main_parity, spare_parity);
  modport lane (input check_done, check_result, sw_write, sw_wdata, main_load, main_in,
                spare_load, spare_in, output status, main_parity, spare_parity);
endinterface : nsr_lane_if

//--- logic/nsr_pkg.sv
// Package: register map, field layout and reset values of the flash status block
package nsr_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_OP_STATUS = 32'h4E000020;
  localparam logic [31:0] ADDR_ECC_LOW   = 32'h4E000024;
  localparam logic [31:0] ADDR_ECC_HIGH  = 32'h4E000028;
  localparam logic [31:0] ADDR_MPAR_LOW  = 32'h4E00002C;
  localparam logic [31:0] ADDR_MPAR_HIGH = 32'h4E000030;
  localparam logic [31:0] ADDR_SPAR      = 32'h4E000034;
  localparam logic [31:0] ADDR_CONTROL   = 32'h4E000040;
  localparam logic [31:0] ADDR_IRQ_MASK  = 32'h4E000044;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ST_READY     = 0;
  localparam int ST_CS_N      = 1;
  localparam int ST_EDGE      = 2;
  localparam int ST_VIOL      = 3;
  localparam int CT_CS_N      = 1;
  localparam int CT_MAIN_FRZ  = 5;
  localparam int CT_SPARE_FRZ = 6;
  localparam int CT_EDGE_SEL  = 8;
  localparam int CT_SOFT_LOCK = 12;
  localparam int CT_TIGHT     = 13;
  localparam int SPAR_W       = 16;

  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [15:0] CONTROL_RESET  = 16'h0002;
  localparam logic [15:0] CONTROL_WMASK  = 16'h3162;
  localparam logic [15:0] IRQ_MASK_RESET = 16'h0000;
  localparam logic [15:0] IRQ_MASK_WMASK = 16'h000C;
  localparam logic [1:0]  STICKY_RESET   = 2'h0;
  localparam logic [31:0] ECC_RESET      = 32'h00000000;
  localparam logic [31:0] ECC_WMASK      = 32'h01FFFFFF;
  localparam logic [31:0] PARITY_RESET   = 32'h00000000;
  localparam logic        PIN_HIGH_RESET = 1'h1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_NONE,
    KIND_SINGLE,
    KIND_MULTI,
    KIND_ECC_AREA
  } nsr_kind_t;

  typedef struct packed {
    logic [6:0]  reserved;
    logic [3:0]  spare_err_index;
    logic [2:0]  spare_err_bit;
    logic [10:0] main_err_index;
    logic [2:0]  main_err_bit;
    nsr_kind_t   spare_err_kind;
    nsr_kind_t   main_err_kind;
  } nsr_ecc_status_t;

endpackage : nsr_pkg

//--- logic/nsr_ready_sync.sv
// Ready/busy pin synchroniser, level filter and selectable edge detector
`timescale 1ns/1ps
module nsr_ready_sync (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic pin_async,
  input  wire logic edge_select,
  output logic      level,
  output logic      edge_pulse
);
  import nsr_pkg::*;

  logic sync1;
  logic sync2;
  logic sync3;
  logic next_level;
  logic agree;

  always_comb begin
    agree      = (sync2 == sync3);
    next_level = agree ? sync3 : level;
    // Select 0 catches low-to-high, select 1 high-to-low
    edge_pulse = agree && (sync3 != level) && (sync3 == !edge_select);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1 <= PIN_HIGH_RESET;
      sync2 <= PIN_HIGH_RESET;
      sync3 <= PIN_HIGH_RESET;
      level <= PIN_HIGH_RESET;
    end else begin
      sync1 <= pin_async;
      sync2 <= sync1;
      sync3 <= sync2;
      level <= next_level;
    end
  end

  a_level_filtered: assert property (@(posedge clock) disable iff (rst)
    $changed(level) |-> $past(sync2) == $past(sync3) && level == $past(sync3))
    else $error("ready level moved without agreeing samples");

  a_edge_direction: assert property (@(posedge clock) disable iff (rst)
    edge_pulse |=> level == !$past(edge_select) && $past(level) == $past(edge_select))
    else $error("edge pulse for the wrong transition");

endmodule : nsr_ready_sync

//--- logic/nsr_top.sv
// Flash status and ECC report block: register slave, flags, interrupt, lanes
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module nsr_top (
  input  wire logic                           clock,
  input  wire logic                           rst,
  // Register port
  input  wire logic [31:0]                    bus_addr,
  input  wire logic [31:0]                    bus_wdata,
  input  wire logic                           bus_write,
  input  wire logic                           bus_read,
  output logic      [31:0]                    bus_rdata,
  output logic                                irq,
  // Flash pins
  input  wire logic                           ready_busy_pin,
  output logic                                chip_select_n,
  // Sequencer and lock logic
  input  wire logic                           prog_erase_attempt,
  input  wire logic                           target_protected,
  output logic                                soft_lock,
  output logic                                lock_tight,
  // ECC engine
  input  wire logic                           ecc_check_done,
  input  wire nsr_pkg::nsr_ecc_status_t [1:0] ecc_check_result,
  input  wire logic                           main_code_active,
  input  wire logic [1:0][31:0]               main_parity_in,
  input  wire logic                           spare_code_active,
  input  wire logic [1:0][15:0]               spare_parity_in,
  output logic                                main_code_freeze,
  output logic                                spare_code_freeze
);
  import nsr_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0]           control;
  logic [15:0]           next_control;
  logic [15:0]           irq_mask;
  logic [15:0]           next_irq_mask;
  logic                  ready_edge_seen;
  logic                  next_edge_seen;
  logic                  locked_write_violation;
  logic                  next_violation;
  logic [31:0]           next_rdata;
  logic                  ready_level;
  logic                  ready_edge;
  logic                  ready_edge_select;
  logic                  wr_status;
  logic                  lock_on;
  logic                  violation_event;
  logic [15:0]           status_word;
  nsr_ecc_status_t [1:0] lane_status;
  logic [1:0][31:0]      lane_main;
  logic [1:0][15:0]      lane_spare;

  // ----------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------
  assign chip_select_n     = control[CT_CS_N];
  assign main_code_freeze  = control[CT_MAIN_FRZ];
  assign spare_code_freeze = control[CT_SPARE_FRZ];
  assign ready_edge_select = control[CT_EDGE_SEL];
  assign soft_lock         = control[CT_SOFT_LOCK];
  assign lock_tight        = control[CT_TIGHT];

  always_comb begin
    next_control  = control;
    next_irq_mask = irq_mask;
    if (bus_write && bus_addr == ADDR_CONTROL) begin
      next_control = bus_wdata[15:0] & CONTROL_WMASK;
      // Lock-tight can only be released by reset
      next_control[CT_TIGHT] = bus_wdata[CT_TIGHT] | control[CT_TIGHT];
    end
    if (bus_write && bus_addr == ADDR_IRQ_MASK) begin
      next_irq_mask = bus_wdata[15:0] & IRQ_MASK_WMASK;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      control  <= CONTROL_RESET;
      irq_mask <= IRQ_MASK_RESET;
    end else begin
      control  <= next_control;
      irq_mask <= next_irq_mask;
    end
  end

  // ----------------------------------------------------------------
  // Ready/busy synchroniser
  // ----------------------------------------------------------------
  nsr_ready_sync u_ready (
    .clock       (clock),
    .rst         (rst),
    .pin_async   (ready_busy_pin),
    .edge_select (ready_edge_select),
    .level       (ready_level),
    .edge_pulse  (ready_edge)
  );

  // ----------------------------------------------------------------
  // Sticky event flags
  // ----------------------------------------------------------------
  assign wr_status       = bus_write && bus_addr == ADDR_OP_STATUS;
  assign lock_on         = soft_lock || lock_tight;
  assign violation_event = prog_erase_attempt && target_protected && lock_on;

  always_comb begin
    next_edge_seen = ready_edge_seen;
    next_violation = locked_write_violation;
    // Writing one clears; a new event in the same cycle keeps the flag set
    if (wr_status && bus_wdata[ST_EDGE]) begin
      next_edge_seen = 1'b0;
    end
    if (wr_status && bus_wdata[ST_VIOL]) begin
      next_violation = 1'b0;
    end
    if (ready_edge) begin
      next_edge_seen = 1'b1;
    end
    if (violation_event) begin
      next_violation = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ready_edge_seen        <= STICKY_RESET[0];
      locked_write_violation <= STICKY_RESET[1];
    end else begin
      ready_edge_seen        <= next_edge_seen;
      locked_write_violation <= next_violation;
    end
  end

  // Level interrupt while an unmasked flag is set
  assign irq = (ready_edge_seen && irq_mask[ST_EDGE])
            || (locked_write_violation && irq_mask[ST_VIOL]);

  // ----------------------------------------------------------------
  // ECC lanes: index 0 is I/O[7:0], index 1 is I/O[15:8]
  // ----------------------------------------------------------------
  nsr_lane_if lane_bus [2] ();

  for (genvar g = 0; g < 2; g++) begin : g_lane
    assign lane_bus[g].check_done   = ecc_check_done;
    assign lane_bus[g].check_result = ecc_check_result[g];
    assign lane_bus[g].sw_write     =
      bus_write && bus_addr == (g == 0 ? ADDR_ECC_LOW : ADDR_ECC_HIGH);
    assign lane_bus[g].sw_wdata     = bus_wdata;
    assign lane_bus[g].main_load    = main_code_active && !main_code_freeze;
    assign lane_bus[g].main_in      = main_parity_in[g];
    assign lane_bus[g].spare_load   = spare_code_active && !spare_code_freeze;
    assign lane_bus[g].spare_in     = spare_parity_in[g];
    assign lane_status[g]           = lane_bus[g].status;
    assign lane_main[g]             = lane_bus[g].main_parity;
    assign lane_spare[g]            = lane_bus[g].spare_parity;

    nsr_ecc_lane u_lane (
      .clock (clock),
      .rst   (rst),
      .port  (lane_bus[g])
    );
  end

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  always_comb begin
    status_word           = 16'h0000;
    status_word[ST_READY] = ready_level;
    status_word[ST_CS_N]  = chip_select_n;
    status_word[ST_EDGE]  = ready_edge_seen;
    status_word[ST_VIOL]  = locked_write_violation;
  end

  always_comb begin
    next_rdata = 32'h00000000;
    if (!bus_read) begin
      next_rdata = 32'h00000000;
    end else if (bus_addr == ADDR_OP_STATUS) begin
      next_rdata = {16'h0000, status_word};
    end else if (bus_addr == ADDR_ECC_LOW) begin
      next_rdata = lane_status[0];
    end else if (bus_addr == ADDR_ECC_HIGH) begin
      next_rdata = lane_status[1];
    end else if (bus_addr == ADDR_MPAR_LOW) begin
      next_rdata = lane_main[0];
    end else if (bus_addr == ADDR_MPAR_HIGH) begin
      next_rdata = lane_main[1];
    end else if (bus_addr == ADDR_SPAR) begin
      next_rdata = {lane_spare[1], lane_spare[0]};
    end else if (bus_addr == ADDR_CONTROL) begin
      next_rdata = {16'h0000, control};
    end else if (bus_addr == ADDR_IRQ_MASK) begin
      next_rdata = {16'h0000, irq_mask};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_rdata <= 32'h00000000;
    end else begin
      bus_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_violation_sets: assert property (@(posedge clock) disable iff (rst)
    prog_erase_attempt && target_protected && (soft_lock || lock_tight)
      |=> locked_write_violation ##1 (locked_write_violation || $past(wr_status)))
    else $error("locked write did not set the violation flag");

  a_no_false_viol: assert property (@(posedge clock) disable iff (rst)
    !locked_write_violation && !(prog_erase_attempt && target_protected)
      |=> !locked_write_violation)
    else $error("violation flag set without a protected attempt");

  a_edge_sets_flag: assert property (@(posedge clock) disable iff (rst)
    ready_edge |=> ready_edge_seen ##0 (irq || !irq_mask[ST_EDGE]))
    else $error("ready edge did not set the flag or interrupt");

  a_flag_holds: assert property (@(posedge clock) disable iff (rst)
    ready_edge_seen && !(wr_status && bus_wdata[ST_EDGE]) |=> ready_edge_seen)
    else $error("ready edge flag dropped without a write of one");

  a_flag_clears: assert property (@(posedge clock) disable iff (rst)
    wr_status && bus_wdata[ST_EDGE] && !ready_edge |=> !ready_edge_seen)
    else $error("write of one did not clear the ready edge flag");

  a_cs_status_read: assert property (@(posedge clock) disable iff (rst)
    bus_read && bus_addr == ADDR_OP_STATUS
      |=> bus_rdata[ST_CS_N] == $past(chip_select_n) && bus_rdata[ST_READY] == $past(ready_level))
    else $error("status read shows wrong pin levels");

  a_ready_reflects: assert property (@(posedge clock) disable iff (rst)
    $rose(ready_level) |-> $past(ready_busy_pin, 3) || $past(ready_busy_pin, 4))
    else $error("ready level rose without the pin being high");

  a_ecc_high_read: assert property (@(posedge clock) disable iff (rst)
    bus_read && bus_addr == ADDR_ECC_HIGH |=> bus_rdata == $past(lane_status[1]))
    else $error("high lane ECC status read back wrong");

  a_kind_capture: assert property (@(posedge clock) disable iff (rst)
    ecc_check_done ##1 bus_read && bus_addr == ADDR_ECC_LOW && !ecc_check_done
      |=> bus_rdata[3:0] == {$past(ecc_check_result[0].spare_err_kind, 2),
                             $past(ecc_check_result[0].main_err_kind, 2)})
    else $error("error kinds not reported as delivered");

  a_spare_loc: assert property (@(posedge clock) disable iff (rst)
    ecc_check_done |=> lane_status[1].spare_err_bit == $past(ecc_check_result[1].spare_err_bit))
    else $error("spare bit location not captured");

  a_rdata_one_cycle: assert property (@(posedge clock) disable iff (rst)
    !bus_read |=> bus_rdata == 32'h00000000)
    else $error("read data stands outside its cycle");

endmodule : nsr_top

//--- testbench/nsr_flash_model.sv
// Flash memory model: holds the ready/busy pin low for a requested busy time
`timescale 1ns/1ps
module nsr_flash_model (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [7:0] busy_len,
  output logic            ready_busy_pin
);
  logic [7:0] busy_left;

  // Open-drain pin with pull-up: released means ready
  assign ready_busy_pin = (busy_left == 8'h00);

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_left <= 8'h00;
    end else if (start) begin
      busy_left <= busy_len;
    end else if (busy_left != 8'h00) begin
      busy_left <= busy_left - 8'h01;
    end
  end
endmodule : nsr_flash_model

//--- testbench/nsr_top_tb_top.sv
// Testbench top: flags, pins, ECC report and parity of the flash status block
`timescale 1ns/1ps
module nsr_top_tb_top;
  import nsr_pkg::*;
  logic                  clock = 1'b0;
  logic                  rst = 1'b1;
  logic [31:0]           bus_addr = 32'h0, bus_wdata = 32'h0, bus_rdata, r0, r1;
  logic                  bus_write = 1'b0, bus_read = 1'b0, irq, chip_select_n;
  logic                  ready_busy_pin, soft_lock, lock_tight, start = 1'b0;
  logic                  prog_erase_attempt = 1'b0, target_protected = 1'b0;
  logic                  ecc_check_done = 1'b0, main_code_active = 1'b0;
  logic                  spare_code_active = 1'b0, main_code_freeze, spare_code_freeze;
  nsr_ecc_status_t [1:0] ecc_check_result = '0;
  logic [1:0][31:0]      main_parity_in = '0;
  logic [1:0][15:0]      spare_parity_in = '0;
  logic [7:0]            busy_len = 8'h0;
  integer                seed = 32'hD9541C8C;
  int                    n_mismatch = 0;
  int                    tests_run = 0;

  always #10 clock = ~clock;

  nsr_top nsr_top_inst (.clock, .rst, .bus_addr, .bus_wdata, .bus_write, .bus_read, .bus_rdata,
    .irq, .ready_busy_pin, .chip_select_n, .prog_erase_attempt, .target_protected, .soft_lock,
    .lock_tight, .ecc_check_done, .ecc_check_result, .main_code_active, .main_parity_in,
    .spare_code_active, .spare_parity_in, .main_code_freeze, .spare_code_freeze);

  nsr_flash_model nsr_flash_model_inst (.clock, .rst, .start, .busy_len, .ready_busy_pin);

  function automatic logic [31:0] ecc_exp(input logic [31:0] r);
    return r & ECC_WMASK;
  endfunction : ecc_exp

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    bus_write <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clock);
    bus_write <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input string what, input logic [31:0] a, input logic [31:0] exp);
    @(posedge clock);
    bus_read <= 1'b1;
    bus_addr <= a;
    @(posedge clock);
    bus_read <= 1'b0;
    #1;
    check(what, bus_rdata, exp);
  endtask : rd

  task automatic go_busy(input logic [7:0] len);
    @(posedge clock);
    start <= 1'b1;
    busy_len <= len;
    @(posedge clock);
    start <= 1'b0;
  endtask : go_busy

  task automatic attempt(input logic prot);
    @(posedge clock);
    prog_erase_attempt <= 1'b1;
    target_protected <= prot;
    @(posedge clock);
    prog_erase_attempt <= 1'b0;
  endtask : attempt

  task automatic load_parity(input logic [31:0] a, input logic [31:0] b);
    @(posedge clock);
    main_parity_in <= {b, a};
    spare_parity_in <= {b[15:0], a[15:0]};
    main_code_active <= 1'b1;
    spare_code_active <= 1'b1;
    @(posedge clock);
    main_code_active <= 1'b0;
    spare_code_active <= 1'b0;
  endtask : load_parity

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd("status", ADDR_OP_STATUS, 32'h3);
    rd("ecc low", ADDR_ECC_LOW, ECC_RESET);
    rd("unmapped", 32'h4E000050, 32'h0);
    $display("test reset done");
    wr(ADDR_IRQ_MASK, 32'hC);
    rd("irq mask", ADDR_IRQ_MASK, 32'hC);
    go_busy(8'd30);
    repeat (8) @(posedge clock);
    rd("busy", ADDR_OP_STATUS, 32'h2);
    repeat (30) @(posedge clock);
    rd("edge", ADDR_OP_STATUS, 32'h7);
    check("irq edge", {31'h0, irq}, 32'h1);
    wr(ADDR_OP_STATUS, 32'h0);
    rd("flag kept", ADDR_OP_STATUS, 32'h7);
    wr(ADDR_OP_STATUS, 32'h4);
    rd("flag clear", ADDR_OP_STATUS, 32'h3);
    check("irq clear", {31'h0, irq}, 32'h0);
    wr(ADDR_CONTROL, 32'h102);
    go_busy(8'd40);
    repeat (10) @(posedge clock);
    rd("fall", ADDR_OP_STATUS, 32'h6);
    wr(ADDR_OP_STATUS, 32'h4);
    repeat (40) @(posedge clock);
    rd("rise ignored", ADDR_OP_STATUS, 32'h3);
    wr(ADDR_CONTROL, 32'h0);
    rd("cs low", ADDR_OP_STATUS, 32'h1);
    check("cs pin", {31'h0, chip_select_n}, 32'h0);
    $display("test ready edge done");
    attempt(1'b1);
    rd("no lock", ADDR_OP_STATUS, 32'h1);
    wr(ADDR_CONTROL, 32'h1002);
    check("soft lock", {30'h0, lock_tight, soft_lock}, 32'h1);
    attempt(1'b0);
    rd("unprotected", ADDR_OP_STATUS, 32'h3);
    attempt(1'b1);
    rd("violation", ADDR_OP_STATUS, 32'hB);
    check("irq viol", {31'h0, irq}, 32'h1);
    wr(ADDR_OP_STATUS, 32'h8);
    rd("viol clear", ADDR_OP_STATUS, 32'h3);
    // Lock-tight survives a write of zero and only reset releases it
    wr(ADDR_CONTROL, 32'h2002);
    wr(ADDR_CONTROL, 32'h0002);
    rd("tight kept", ADDR_CONTROL, 32'h2002);
    check("lock pins", {30'h0, lock_tight, soft_lock}, 32'h2);
    attempt(1'b1);
    rd("tight viol", ADDR_OP_STATUS, 32'hB);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd("reset viol", ADDR_OP_STATUS, 32'h3);
    rd("reset ctrl", ADDR_CONTROL, {16'h0000, CONTROL_RESET});
    check("irq reset", {31'h0, irq}, 32'h0);
    $display("test lock done");
    // Each lane gets its own random report, every kind code on both fields
    for (int k = 0; k < 4; k++) begin
      r0 = $random(seed);
      r1 = $random(seed);
      r0[3:0] = {2'(3 - k), 2'(k)};
      r1[3:0] = {2'(k), 2'(3 - k)};
      @(posedge clock);
      ecc_check_done <= 1'b1;
      ecc_check_result <= {nsr_ecc_status_t'(r1), nsr_ecc_status_t'(r0)};
      // Read the low lane in the cycle right after the result arrives
      @(posedge clock);
      ecc_check_done <= 1'b0;
      bus_read <= 1'b1;
      bus_addr <= ADDR_ECC_LOW;
      @(posedge clock);
      bus_read <= 1'b0;
      #1;
      check("ecc low", bus_rdata, ecc_exp(r0));
      rd("ecc high", ADDR_ECC_HIGH, ecc_exp(r1));
    end
    wr(ADDR_ECC_LOW, 32'hFFFFFFFF);
    rd("ecc write", ADDR_ECC_LOW, ecc_exp(32'hFFFFFFFF));
    $display("test ecc done");
    r0 = $random(seed);
    r1 = $random(seed);
    load_parity(r0, r1);
    rd("main low", ADDR_MPAR_LOW, r0);
    rd("main high", ADDR_MPAR_HIGH, r1);
    rd("spare", ADDR_SPAR, {r1[15:0], r0[15:0]});
    wr(ADDR_CONTROL, 32'h62);
    check("freeze", {30'h0, main_code_freeze, spare_code_freeze}, 32'h3);
    load_parity(~r0, ~r1);
    rd("main frozen", ADDR_MPAR_LOW, r0);
    rd("spare frozen", ADDR_SPAR, {r1[15:0], r0[15:0]});
    wr(ADDR_CONTROL, 32'h22);
    load_parity(~r0, ~r1);
    rd("main held", ADDR_MPAR_HIGH, r1);
    rd("spare free", ADDR_SPAR, {~r1[15:0], ~r0[15:0]});
    $display("test parity done");
    report_and_stop();
  end
endmodule : nsr_top_tb_top
